//--- msd_pkg.sv
// Functional notes
// - Program and data spaces are separate 64kB spaces from 0000h to FFFFh.
// - On-chip range served internally; accesses above it go to external port bus.
// - Both hardware configuration registers change only in flash programming mode.
// - 3-bit partition select splits flash; 111 is all program, 000/001 all data.
// - Partition decode parameterised by 4kB, 8kB, 16kB or 32kB flash size.
// - Zero program flash allocation sends every fetch to external memory.
// - Fetch above highest internal program address goes to external program memory.
// - Internal program flash shrinks from its top when data flash is allocated.
// - Data moves to 0000h-03FFh hit 1kB SRAM; data flash starts at 0400h.
// - Flash write via move select lets data moves reach either flash partition.
// - Instructions never execute from the data flash partition.
// - Lock bit blocks program flash erase and write; data flash stays usable.
// - Internal data accesses never show transferred data on the low port.
// - Flash erased before write, in 128-byte pages, writes by data moves.
// - Code-table read path returns program space bytes, separate from fetch.
// - Direct 00h-7Fh scratchpad, direct 80h-FFh SPECIAL_FUNCTION_REGISTER, indirect 80h-FFh upper RAM.
// - Scratchpad bytes 20h-2Fh also reachable as 128 single bits.
// - Only SFRs ending in 0 or 8 are bit addressable; instruction type decides.
// - Four banks of eight working registers; bank chosen by status word field.
// - Working registers 0 and 1 of active bank act as indirect pointers.
// - External access enabled only when second config bits 0 and 1 are clear.
// - With external access enabled, low port driven zero during internal data phase.
package msd_pkg;
  localparam logic [7:0] MEM_WSEL_ADDR = 8'h8F;
  localparam logic [7:0] STATUS_ADDR = 8'hD0;
  localparam int FLASH_WRITE_BIT = 0;
  localparam int LOCK_BIT = 0;
  localparam int BANK_LSB = 3;
  localparam int EXT_OFF0_BIT = 0;
  localparam int EXT_OFF1_BIT = 1;
  localparam logic [2:0] PART_DEFAULT = 3'h7;
  localparam logic [7:0] MEM_WSEL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] HCR_RESET = 8'hFF;
  localparam logic [15:0] SRAM_TOP = 16'h03FF;
  localparam logic [15:0] DFLASH_BASE = 16'h0400;
  localparam logic [7:0] BIT_BYTE_BASE = 8'h20;
  localparam int PAGE_BYTES = 128;
  localparam int PAGE_SHIFT = 7;
  typedef enum logic [1:0] {
    MSD_TGT_NONE,
    MSD_TGT_INT,
    MSD_TGT_EXT
  } msd_tgt_type;
  typedef enum logic [1:0] {
    MSD_RSP_SCRATCH,
    MSD_RSP_SFR,
    MSD_RSP_BIT
  } msd_rsp_type;

  // Program flash size in 1kB units, by select and flash size in kB
  function automatic logic [5:0] prog_kb(input logic [2:0] sel, input int size_kb);
    logic [5:0] sz;
    sz = size_kb[5:0];
    unique case (sel)
      3'h0, 3'h1: prog_kb = 6'h00;
      3'h2: prog_kb = (sz >= 6'h20) ? sz - 6'h10 : 6'h00;
      3'h3: prog_kb = (sz >= 6'h10) ? sz - 6'h08 : 6'h00;
      3'h4: prog_kb = (sz >= 6'h08) ? sz - 6'h04 : 6'h00;
      3'h5: prog_kb = sz - 6'h02;
      3'h6: prog_kb = sz - 6'h01;
      default: prog_kb = sz;
    endcase
  endfunction
endpackage

//--- msd_reg_if.sv
`timescale 1ns/100ps
interface msd_reg_if;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport owner (input wr_en, input addr, input wdata, output rdata);
  modport user (output wr_en, output addr, output wdata, input rdata);
endinterface

//--- msd_scratch_ram.sv
`timescale 1ns/100ps
module msd_scratch_ram (
  input wire logic core_clk_in,
  msd_reg_if.owner port
);
  logic [7:0] mem [0:255];
  logic [7:0] rdata_r;
  always_ff @(posedge core_clk_in) begin
    if (port.wr_en) begin
      mem[port.addr] <= port.wdata;
    end
    rdata_r <= mem[port.addr];
  end
  assign port.rdata = rdata_r;
endmodule

//--- msd_decoder.sv
`timescale 1ns/100ps
module msd_decoder #(
  parameter int FLASH_KB = 32
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic prog_mode_in,
  input wire logic cfg_load_in,
  input wire logic [7:0] cfg_first_in,
  input wire logic [7:0] cfg_second_in,
  input wire logic fetch_in,
  input wire logic code_read_in,
  input wire logic [15:0] code_addr_in,
  input wire logic move_in,
  input wire logic move_wr_in,
  input wire logic move_erase_in,
  input wire logic [15:0] move_addr_in,
  input wire logic [7:0] move_wdata_in,
  input wire logic reg_in,
  input wire logic reg_wr_in,
  input wire logic reg_indirect_in,
  input wire logic reg_bit_in,
  input wire logic reg_work_in,
  input wire logic [2:0] work_sel_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic code_ext_out,
  output logic code_int_out,
  output logic [15:0] code_flash_addr_out,
  output logic data_sram_out,
  output logic data_flash_out,
  output logic data_ext_out,
  output logic data_refused_out,
  output logic [15:0] data_flash_addr_out,
  output logic erase_page_out,
  output logic [8:0] erase_page_num_out,
  output logic ext_enable_out,
  output logic [7:0] low_port_out,
  output logic [7:0] high_port_out,
  output logic sfr_sel_out,
  output logic [7:0] sfr_addr_out,
  output logic bit_access_out,
  output logic [2:0] bit_index_out,
  output logic [7:0] reg_rdata_out,
  output logic [7:0] pointer_zero_out,
  output logic [7:0] pointer_one_out,
  output logic [2:0] part_sel_out
);
  localparam logic [16:0] FLASH_BYTES = 17'(FLASH_KB * 1024);
  logic [7:0] hcr_first_r, hcr_first_nxt;
  logic [7:0] hcr_second_r, hcr_second_nxt;
  logic [7:0] mem_wsel_r, mem_wsel_nxt;
  logic [7:0] status_r, status_nxt;
  logic ext_en_r, ext_en_nxt;
  logic [16:0] prog_top;
  logic ext_en;
  logic [1:0] bank;
  msd_reg_if ram_port ();
  msd_scratch_ram u_ram (
    .core_clk_in(core_clk_in),
    .port(ram_port)
  );

  // Configuration and local register state
  always_comb begin
    hcr_first_nxt = hcr_first_r;
    hcr_second_nxt = hcr_second_r;
    mem_wsel_nxt = mem_wsel_r;
    status_nxt = status_r;
    if (cfg_load_in && prog_mode_in) begin
      hcr_first_nxt = cfg_first_in;
      hcr_second_nxt = cfg_second_in;
    end
    // Own flop so the enable pin never glitches
    ext_en_nxt = !hcr_second_nxt[msd_pkg::EXT_OFF0_BIT]
      && !hcr_second_nxt[msd_pkg::EXT_OFF1_BIT];
    if (reg_in && reg_wr_in && !reg_indirect_in && !reg_bit_in && !reg_work_in) begin
      if (reg_addr_in == msd_pkg::MEM_WSEL_ADDR) begin
        mem_wsel_nxt = reg_wdata_in;
      end
      if (reg_addr_in == msd_pkg::STATUS_ADDR) begin
        status_nxt = reg_wdata_in;
      end
    end
  end
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hcr_first_r <= msd_pkg::HCR_RESET;
      hcr_second_r <= msd_pkg::HCR_RESET;
      mem_wsel_r <= msd_pkg::MEM_WSEL_RESET;
      status_r <= msd_pkg::STATUS_RESET;
      ext_en_r <= 1'b0;
    end else begin
      hcr_first_r <= hcr_first_nxt;
      hcr_second_r <= hcr_second_nxt;
      mem_wsel_r <= mem_wsel_nxt;
      status_r <= status_nxt;
      ext_en_r <= ext_en_nxt;
    end
  end

  // Partition top; data flash sits above the SRAM
  always_comb begin
    prog_top = {1'b0, msd_pkg::prog_kb(hcr_first_r[7:5], FLASH_KB), 10'h000};
    ext_en = !hcr_second_r[msd_pkg::EXT_OFF0_BIT] && !hcr_second_r[msd_pkg::EXT_OFF1_BIT];
    bank = status_r[msd_pkg::BANK_LSB +: 2];
  end

  // Program side: fetch and code-table read
  logic code_int_nxt, code_ext_nxt;
  logic [15:0] code_faddr_nxt;
  logic code_int_r, code_ext_r;
  logic [15:0] code_faddr_r;
  always_comb begin
    code_int_nxt = 1'b0;
    code_ext_nxt = 1'b0;
    code_faddr_nxt = code_addr_in;
    if (fetch_in || code_read_in) begin
      // Fetches never land in data flash: it lies above prog_top
      if ({1'b0, code_addr_in} < prog_top) begin
        code_int_nxt = 1'b1;
      end else begin
        code_ext_nxt = ext_en;
      end
    end
  end

  // Data side: SRAM, data flash, program flash via move, external
  logic [16:0] dflash_end, maddr;
  logic sram_nxt, dfl_nxt, dext_nxt, refused_nxt, erase_nxt;
  logic [15:0] dfaddr_nxt;
  logic sram_r, dfl_r, dext_r, refused_r, erase_r;
  logic [15:0] dfaddr_r;
  always_comb begin
    dflash_end = (FLASH_BYTES - prog_top) + {1'b0, msd_pkg::DFLASH_BASE};
    maddr = {1'b0, move_addr_in};
    sram_nxt = 1'b0;
    dfl_nxt = 1'b0;
    dext_nxt = 1'b0;
    refused_nxt = 1'b0;
    erase_nxt = 1'b0;
    dfaddr_nxt = 16'h0000;
    if (move_in) begin
      if (move_addr_in <= msd_pkg::SRAM_TOP) begin
        sram_nxt = !move_erase_in;
      end else if (maddr < dflash_end) begin
        dfl_nxt = 1'b1;
        dfaddr_nxt = 16'(prog_top + maddr - {1'b0, msd_pkg::DFLASH_BASE});
        erase_nxt = move_erase_in;
      end else if (mem_wsel_r[msd_pkg::FLASH_WRITE_BIT] && maddr < prog_top) begin
        // Locked program flash still reads, refuses write and erase
        if ((move_wr_in || move_erase_in) && !hcr_first_r[msd_pkg::LOCK_BIT]) begin
          refused_nxt = 1'b1;
        end else begin
          dfl_nxt = 1'b1;
          dfaddr_nxt = move_addr_in;
          erase_nxt = move_erase_in;
        end
      end else begin
        dext_nxt = ext_en;
      end
    end
  end

  // Port bus: address high on high port, address low or write data on low port, low port held zero for internal accesses
  logic [7:0] low_nxt, high_nxt, low_r, high_r;
  always_comb begin
    low_nxt = 8'h00;
    high_nxt = 8'h00;
    if (ext_en) begin
      if (fetch_in || code_read_in) begin
        high_nxt = code_addr_in[15:8];
        low_nxt = code_int_nxt ? 8'h00 : code_addr_in[7:0];
      end else if (move_in) begin
        high_nxt = move_addr_in[15:8];
        low_nxt = dext_nxt ? (move_wr_in ? move_wdata_in : move_addr_in[7:0]) : 8'h00;
      end
    end
  end

  // Register space
  logic [7:0] raddr;
  logic sfr_nxt, bit_nxt;
  logic [2:0] bidx_nxt;
  logic sfr_r, bit_r;
  logic [2:0] bidx_r;
  logic [7:0] saddr_r;
  always_comb begin
    raddr = reg_addr_in;
    sfr_nxt = 1'b0;
    bit_nxt = 1'b0;
    bidx_nxt = 3'h0;
    if (reg_work_in) begin
      raddr = {3'h0, bank, work_sel_in};
    end else if (reg_bit_in) begin
      bit_nxt = 1'b1;
      bidx_nxt = reg_addr_in[2:0];
      if (reg_addr_in[7]) begin
        raddr = {reg_addr_in[7:3], 3'h0};
        sfr_nxt = reg_in;
      end else begin
        raddr = msd_pkg::BIT_BYTE_BASE + {4'h0, reg_addr_in[6:3]};
      end
    end else if (reg_addr_in[7] && !reg_indirect_in) begin
      sfr_nxt = reg_in;
    end
  end
  assign ram_port.addr = raddr;
  assign ram_port.wdata = reg_wdata_in;
  assign ram_port.wr_en = reg_in && reg_wr_in && !sfr_nxt && !reg_bit_in;

  // Pointers loaded by writes to bank-relative working registers 0 and 1
  logic [7:0] ptr0_r, ptr1_r;
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ptr0_r <= 8'h00;
      ptr1_r <= 8'h00;
    end else if (reg_in && reg_wr_in && ram_port.wr_en) begin
      if (raddr == {3'h0, bank, 3'h0}) begin
        ptr0_r <= reg_wdata_in;
      end
      if (raddr == {3'h0, bank, 3'h1}) begin
        ptr1_r <= reg_wdata_in;
      end
    end
  end

  // Pointer copies are per active bank; a bank switch needs reloading by software
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      code_int_r <= 1'b0;
      code_ext_r <= 1'b0;
      code_faddr_r <= 16'h0000;
      sram_r <= 1'b0;
      dfl_r <= 1'b0;
      dext_r <= 1'b0;
      refused_r <= 1'b0;
      erase_r <= 1'b0;
      dfaddr_r <= 16'h0000;
      low_r <= 8'h00;
      high_r <= 8'h00;
      sfr_r <= 1'b0;
      bit_r <= 1'b0;
      bidx_r <= 3'h0;
      saddr_r <= 8'h00;
    end else begin
      code_int_r <= code_int_nxt;
      code_ext_r <= code_ext_nxt;
      code_faddr_r <= code_faddr_nxt;
      sram_r <= sram_nxt;
      dfl_r <= dfl_nxt;
      dext_r <= dext_nxt;
      refused_r <= refused_nxt;
      erase_r <= erase_nxt;
      dfaddr_r <= dfaddr_nxt;
      low_r <= low_nxt;
      high_r <= high_nxt;
      sfr_r <= sfr_nxt;
      bit_r <= bit_nxt;
      bidx_r <= bidx_nxt;
      saddr_r <= raddr;
    end
  end

  // SFR reads give the 8Fh register, any other SFR address gives status; non-SFR reads come from scratchpad
  logic [7:0] rdata_r;
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= (raddr == msd_pkg::MEM_WSEL_ADDR) ? mem_wsel_r : status_r;
    end
  end

  assign code_int_out = code_int_r;
  assign code_ext_out = code_ext_r;
  assign code_flash_addr_out = code_faddr_r;
  assign data_sram_out = sram_r;
  assign data_flash_out = dfl_r;
  assign data_ext_out = dext_r;
  assign data_refused_out = refused_r;
  assign data_flash_addr_out = dfaddr_r;
  assign erase_page_out = erase_r;
  assign erase_page_num_out = dfaddr_r[15:msd_pkg::PAGE_SHIFT];
  assign ext_enable_out = ext_en_r;
  assign low_port_out = low_r;
  assign high_port_out = high_r;
  assign sfr_sel_out = sfr_r;
  assign sfr_addr_out = saddr_r;
  assign bit_access_out = bit_r;
  assign bit_index_out = bidx_r;
  assign reg_rdata_out = sfr_r ? rdata_r : ram_port.rdata;
  assign pointer_zero_out = ptr0_r;
  assign pointer_one_out = ptr1_r;
  assign part_sel_out = hcr_first_r[7:5];

  property p_fetch_ext;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      (fetch_in && ext_en && {1'b0, code_addr_in} >= prog_top) |=> code_ext_out && !code_int_out;
  endproperty
  a_fetch_ext: assert property (p_fetch_ext) else $error("High fetch not external");
  property p_sram;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      (move_in && !move_erase_in && move_addr_in <= 16'h03FF) |=> data_sram_out && !data_ext_out;
  endproperty
  a_sram: assert property (p_sram) else $error("Low data move missed SRAM");
  property p_hcr_hold;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      !prog_mode_in |=> $stable(hcr_first_r) && $stable(hcr_second_r);
  endproperty
  a_hcr_hold: assert property (p_hcr_hold) else $error("Config changed outside programming");
  property p_low_zero;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      (move_in && move_addr_in <= 16'h03FF) |=> low_port_out == 8'h00;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("Internal data leaked on low port");
  property p_no_ext;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      !ext_en |=> !code_ext_out && !data_ext_out;
  endproperty
  a_no_ext: assert property (p_no_ext) else $error("External access while disabled");
  property p_sfr;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      (reg_in && !reg_bit_in && !reg_work_in) |=> sfr_sel_out == $past(reg_addr_in[7] && !reg_indirect_in);
  endproperty
  a_sfr: assert property (p_sfr) else $error("Register space split wrong");
  property p_lock;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      (move_in && move_wr_in && !hcr_first_r[0] && {1'b0, move_addr_in} < prog_top
       && move_addr_in > 16'h03FF && {1'b0, move_addr_in} >= dflash_end) |=> !data_flash_out;
  endproperty
  a_lock: assert property (p_lock) else $error("Locked program flash written");
  property p_bank;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      (reg_in && reg_work_in) |=> sfr_addr_out == {3'h0, $past(status_r[4:3]), $past(work_sel_in)};
  endproperty
  a_bank: assert property (p_bank) else $error("Working register bank wrong");
endmodule

//--- msd_cpu_model.sv
`timescale 1ns/100ps
module msd_cpu_model (
  input wire logic core_clk_in,
  output logic fetch_out,
  output logic code_read_out,
  output logic [15:0] code_addr_out,
  output logic move_out,
  output logic move_wr_out,
  output logic move_erase_out,
  output logic [15:0] move_addr_out,
  output logic [7:0] move_wdata_out,
  output logic reg_out,
  output logic [3:0] reg_kind_out,
  output logic [2:0] work_sel_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out
);
  initial begin
    fetch_out = 1'b0;
    code_read_out = 1'b0;
    code_addr_out = 16'h0000;
    move_out = 1'b0;
    move_wr_out = 1'b0;
    move_erase_out = 1'b0;
    move_addr_out = 16'h0000;
    move_wdata_out = 8'h00;
    reg_out = 1'b0;
    reg_kind_out = 4'h0;
    work_sel_out = 3'h0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
  end
  // Fetch or code-table read, one pulse; address scrambled once released
  task automatic code(input logic rd, input logic [15:0] a);
    @(posedge core_clk_in);
    #1;
    fetch_out = !rd;
    code_read_out = rd;
    code_addr_out = a;
    @(posedge core_clk_in);
    #1;
    fetch_out = 1'b0;
    code_read_out = 1'b0;
    code_addr_out = ~a;
  endtask
  // Data move, one pulse; address and data scrambled once released
  task automatic move(input logic wr, input logic er, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    #1;
    move_out = 1'b1;
    move_wr_out = wr;
    move_erase_out = er;
    move_addr_out = a;
    move_wdata_out = d;
    @(posedge core_clk_in);
    #1;
    move_out = 1'b0;
    move_wr_out = 1'b0;
    move_erase_out = 1'b0;
    move_addr_out = ~a;
    move_wdata_out = ~d;
  endtask
  // Kind bits: write, indirect, bit, working register
  task automatic regx(input logic [3:0] k, input logic [2:0] ws, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge core_clk_in);
    #1;
    reg_out = 1'b1;
    reg_kind_out = k;
    work_sel_out = ws;
    reg_addr_out = a;
    reg_wdata_out = d;
    @(posedge core_clk_in);
    #1;
    reg_out = 1'b0;
    reg_kind_out = 4'h0;
    work_sel_out = ~ws;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask
endmodule

//--- tb_msd_decoder.sv
`timescale 1ns/100ps
module tb_msd_decoder;
  logic core_clk_in, rst_b_in, prog_mode_in, cfg_load_in;
  logic [7:0] cfg_first_in, cfg_second_in;
  logic fe, cr, mv, mw, me, rg;
  logic [3:0] rk;
  logic [2:0] ws;
  logic [15:0] ca, ma;
  logic [7:0] md, ra, rd;
  logic code_ext_out, code_int_out, data_sram_out, data_flash_out, data_ext_out;
  logic data_refused_out, erase_page_out, ext_enable_out, sfr_sel_out, bit_access_out;
  logic [15:0] code_flash_addr_out, data_flash_addr_out;
  logic [8:0] erase_page_num_out;
  logic [7:0] low_port_out, high_port_out, sfr_addr_out, reg_rdata_out;
  logic [7:0] pointer_zero_out, pointer_one_out;
  logic [2:0] bit_index_out, part_sel_out;
  int err_total, total_checks, i, top, dk;
  integer seed;
  logic [15:0] a;
  int pk[8] = '{0, 0, 16, 24, 28, 30, 31, 32};
  msd_cpu_model i_cpu (.core_clk_in(core_clk_in), .fetch_out(fe), .code_read_out(cr),
    .code_addr_out(ca), .move_out(mv), .move_wr_out(mw), .move_erase_out(me),
    .move_addr_out(ma), .move_wdata_out(md), .reg_out(rg), .reg_kind_out(rk),
    .work_sel_out(ws), .reg_addr_out(ra), .reg_wdata_out(rd));
  msd_decoder #(.FLASH_KB(32)) i_dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
    .prog_mode_in(prog_mode_in), .cfg_load_in(cfg_load_in), .cfg_first_in(cfg_first_in),
    .cfg_second_in(cfg_second_in), .fetch_in(fe), .code_read_in(cr), .code_addr_in(ca),
    .move_in(mv), .move_wr_in(mw), .move_erase_in(me), .move_addr_in(ma),
    .move_wdata_in(md), .reg_in(rg), .reg_wr_in(rk[3]), .reg_indirect_in(rk[2]),
    .reg_bit_in(rk[1]), .reg_work_in(rk[0]), .work_sel_in(ws), .reg_addr_in(ra),
    .reg_wdata_in(rd), .code_ext_out(code_ext_out), .code_int_out(code_int_out),
    .code_flash_addr_out(code_flash_addr_out), .data_sram_out(data_sram_out),
    .data_flash_out(data_flash_out), .data_ext_out(data_ext_out),
    .data_refused_out(data_refused_out), .data_flash_addr_out(data_flash_addr_out),
    .erase_page_out(erase_page_out), .erase_page_num_out(erase_page_num_out),
    .ext_enable_out(ext_enable_out), .low_port_out(low_port_out),
    .high_port_out(high_port_out), .sfr_sel_out(sfr_sel_out), .sfr_addr_out(sfr_addr_out),
    .bit_access_out(bit_access_out), .bit_index_out(bit_index_out),
    .reg_rdata_out(reg_rdata_out), .pointer_zero_out(pointer_zero_out),
    .pointer_one_out(pointer_one_out), .part_sel_out(part_sel_out));
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end
  // Flash bytes below this belong to the program partition
  function automatic int prog_top(input logic [2:0] s);
    prog_top = pk[s] * 1024;
  endfunction
  task automatic chk_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t value got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic load(input logic pm, input logic [7:0] f, input logic [7:0] s);
    @(posedge core_clk_in);
    #1;
    prog_mode_in = pm;
    cfg_first_in = f;
    cfg_second_in = s;
    cfg_load_in = 1'b1;
    @(posedge core_clk_in);
    #1;
    cfg_load_in = 1'b0;
    prog_mode_in = 1'b0;
    cfg_first_in = ~f;
    cfg_second_in = ~s;
    @(posedge core_clk_in);
    #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end
  initial begin
    seed = 72;
    rst_b_in = 1'b0;
    prog_mode_in = 1'b0;
    cfg_load_in = 1'b0;
    cfg_first_in = 8'h00;
    cfg_second_in = 8'h00;
    repeat (2) @(posedge core_clk_in);
    #1 rst_b_in = 1'b1;
    chk_val(16'(part_sel_out), 16'h0007);
    chk_flag(ext_enable_out, 1'b0);
    load(1'b0, 8'h1F, 8'hFC);
    chk_val(16'(part_sel_out), 16'h0007);
    chk_flag(ext_enable_out, 1'b0);
    for (i = 3; i >= 0; i--) begin
      load(1'b1, 8'hFF, {6'h3F, 2'(i)});
      chk_flag(ext_enable_out, i == 0);
    end
    for (i = 0; i < 8; i++) begin
      load(1'b1, {3'(i), 5'h1F}, 8'hFC);
      top = prog_top(3'(i));
      dk = 32768 - top;
      chk_val(16'(part_sel_out), 16'(i));
      if (top > 0) begin
        i_cpu.code(1'b0, 16'(top - 1));
        chk_flag(code_int_out, 1'b1);
        chk_val(code_flash_addr_out, 16'(top - 1));
      end
      i_cpu.code(1'b1, 16'(top));
      chk_flag(code_ext_out, 1'b1);
      chk_flag(code_int_out, 1'b0);
      if (dk > 0) begin
        i_cpu.move(1'b0, 1'b0, 16'(1024 + dk - 1), 8'h00);
        chk_flag(data_flash_out, 1'b1);
        chk_val(data_flash_addr_out, 16'(top + dk - 1));
      end
    end
    load(1'b1, 8'hDF, 8'hFC);
    for (i = 0; i < 60; i++) begin
      a = 16'($random(seed)) & ((i % 2) ? 16'h0FFF : 16'hFFFF);
      i_cpu.code(i[2], a);
      chk_flag(code_int_out, a < 16'h7C00);
      chk_flag(code_ext_out, a >= 16'h7C00);
      chk_val(16'(high_port_out), {8'h00, a[15:8]});
      chk_val(16'(low_port_out), (a < 16'h7C00) ? 16'h0000 : {8'h00, a[7:0]});
      i_cpu.move(1'b0, 1'b0, a, 8'h00);
      chk_flag(data_sram_out, a <= 16'h03FF);
      chk_flag(data_flash_out, a >= 16'h0400 && a < 16'h0800);
      chk_flag(data_ext_out, a >= 16'h0800);
      if (a < 16'h0800) chk_val(16'(low_port_out), 16'h0000);
    end
    i_cpu.move(1'b1, 1'b0, 16'h0010, 8'hA5);
    chk_flag(data_sram_out, 1'b1);
    chk_val(16'(low_port_out), 16'h0000);
    i_cpu.move(1'b0, 1'b1, 16'h0480, 8'h00);
    chk_flag(erase_page_out, 1'b1);
    chk_val(16'(erase_page_num_out), 16'h00F9);
    i_cpu.move(1'b1, 1'b0, 16'h0480, 8'h3C);
    chk_flag(data_flash_out, 1'b1);
    load(1'b1, 8'hDE, 8'hFC);
    i_cpu.regx(4'h8, 3'h0, 8'h8F, 8'h01);
    i_cpu.regx(4'h0, 3'h0, 8'h8F, 8'h00);
    chk_val(16'(reg_rdata_out), 16'h0001);
    i_cpu.move(1'b1, 1'b0, 16'h0500, 8'h5A);
    chk_flag(data_flash_out, 1'b1);
    chk_flag(data_refused_out, 1'b0);
    i_cpu.move(1'b1, 1'b0, 16'h1000, 8'h66);
    chk_flag(data_refused_out, 1'b1);
    chk_flag(data_flash_out, 1'b0);
    i_cpu.move(1'b0, 1'b0, 16'h1000, 8'h00);
    chk_flag(data_flash_out, 1'b1);
    chk_val(data_flash_addr_out, 16'h1000);
    for (i = 0; i < 4; i++) begin
      i_cpu.regx(4'h8, 3'h0, 8'hD0, 8'(i << 3));
      i_cpu.regx(4'h9, 3'h1, 8'h00, 8'(8'h40 + i));
      i_cpu.regx(4'h9, 3'h0, 8'h00, 8'(8'h50 + i));
      i_cpu.regx(4'h0, 3'h0, 8'(8 * i + 1), 8'h00);
      chk_val(16'(reg_rdata_out), 16'(8'h40 + i));
      chk_val(16'(pointer_one_out), 16'(8'h40 + i));
      chk_val(16'(pointer_zero_out), 16'(8'h50 + i));
    end
    i_cpu.regx(4'hC, 3'h0, 8'h90, 8'h77);
    i_cpu.regx(4'h4, 3'h0, 8'h90, 8'h00);
    chk_flag(sfr_sel_out, 1'b0);
    chk_val(16'(reg_rdata_out), 16'h0077);
    i_cpu.regx(4'h0, 3'h0, 8'h90, 8'h00);
    chk_flag(sfr_sel_out, 1'b1);
    i_cpu.regx(4'h0, 3'h0, 8'h7F, 8'h00);
    chk_flag(sfr_sel_out, 1'b0);
    i_cpu.regx(4'h2, 3'h0, 8'h13, 8'h00);
    chk_flag(bit_access_out, 1'b1);
    chk_val(16'(bit_index_out), 16'h0003);
    i_cpu.regx(4'h2, 3'h0, 8'h8B, 8'h00);
    chk_flag(sfr_sel_out, 1'b1);
    chk_val(16'(sfr_addr_out), 16'h0088);
    i_cpu.regx(4'h0, 3'h0, 8'h8B, 8'h00);
    chk_flag(bit_access_out, 1'b0);
    wrap_up();
  end
endmodule
